// ### dv/clk_sel_sva.sv
`default_nettype none
module clk_sel_sva #(
  parameter logic [clk_sel_pkg::FAIL_W-1:0] FAIL_LIMIT =
    clk_sel_pkg::FAIL_W'(clk_sel_pkg::FAIL_LIMIT_DEFAULT)
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [2:0] clock_source_select,
  input wire logic wake_from_sleep,
  input wire logic osc_in_pin,
  input wire clk_sel_pkg::reg_req_t reg_req,
  input wire logic [clk_sel_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic sys_clk_out,
  input wire logic [1:0] amp_gain,
  input wire clk_sel_pkg::pin_drive_t osc_out_or_clock_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up;
  logic [10:0] st;
  logic [10:0] still;
  logic osc_q;
  logic clk_q;
  wire logic settled = (up == 3'h7);
  wire logic xtal = (clock_source_select < 3'h3);
  // rising crystal edges since reset or wake, and cycles since the clock output last moved
  always_ff @(posedge sys_clk) begin
    osc_q <= osc_in_pin;
    clk_q <= sys_clk_out;
    up <= srst ? 3'h0 : (settled ? up : up + 3'h1);
    if (srst || wake_from_sleep) st <= 11'h000;
    else if (osc_in_pin && !osc_q && st != 11'h400) st <= st + 11'h001;
    if (srst || sys_clk_out != clk_q) still <= 11'h000;
    else if (still != 11'h7FF) still <= still + 11'h001;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_reset_quiet: assert property (
    $past(srst) |-> !sys_clk_out && !irq && amp_gain == 2'h0 && osc_out_or_clock_out_pin.oe_n)
    else $error("outputs active right after reset");
  a_gain_map: assert property (
    settled |-> amp_gain == (xtal ? clock_source_select[1:0] + 2'h1 : 2'h0))
    else $error("amplifier gain does not match mode");
  a_xtal_pin: assert property (
    settled && xtal |-> !osc_out_or_clock_out_pin.oe_n)
    else $error("second pin not driven in crystal mode");
  a_startup_hold: assert property (
    settled && xtal && st != 11'h400 && !clk_q |-> !sys_clk_out)
    else $error("clock released before startup count");
  a_clock_alive: assert property (
    settled && !xtal |-> still < 11'h7D0)
    else $error("clock output stuck in non crystal mode");
  a_rdata_idle: assert property (
    !$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (
    $past(reg_req.rd) && $past(reg_req.addr) > 4'h4 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_mode: assert property (
    settled && $past(reg_req.rd) && $past(reg_req.addr) == 4'h1
    |-> reg_rdata[6:4] == clock_source_select)
    else $error("status mode field wrong");
  cover property (settled && xtal && $rose(sys_clk_out));
  cover property ($rose(irq));
  cover property ($past(reg_req.rd) && reg_rdata != 8'h00);
endmodule : clk_sel_sva
bind system_clock_source_select clk_sel_sva #(.FAIL_LIMIT(FAIL_LIMIT)) i_clk_sel_sva (
  .sys_clk(sys_clk), .srst(srst), .clock_source_select(clock_source_select),
  .wake_from_sleep(wake_from_sleep), .osc_in_pin(osc_in_pin), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .irq(irq), .sys_clk_out(sys_clk_out), .amp_gain(amp_gain),
  .osc_out_or_clock_out_pin(osc_out_or_clock_out_pin));
`default_nettype wire

// ### dv/ext_osc_model.sv
`default_nettype none
module ext_osc_model (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [10:0] half,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] cnt;
  // a stopped source rests low
  always_ff @(posedge sys_clk) begin
    if (!run) begin
      cnt <= 11'h001;
      osc <= 1'b0;
    end else if (cnt >= half) begin
      cnt <= 11'h001;
      osc <= !osc;
    end else begin
      cnt <= cnt + 11'h001;
    end
  end
endmodule : ext_osc_model
`default_nettype wire

// ### dv/system_clock_source_select_tb_top.sv
`default_nettype none
module system_clock_source_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] strap = 3'h7;
  logic wake = 1'b0;
  logic gpio_out = 1'b0;
  logic gpio_oe = 1'b0;
  logic ext_run = 1'b0;
  logic tmr_run = 1'b0;
  logic [10:0] ext_half = 11'h003;
  clk_sel_pkg::reg_req_t req = '0;
  logic osc;
  logic tmr;
  logic [7:0] rdata;
  logic irq;
  logic clk_out;
  logic [1:0] gain;
  clk_sel_pkg::pin_drive_t pin;
  int failures = 0;
  int total_checks = 0;
  always #10 sys_clk = !sys_clk;
  system_clock_source_select #(.FAIL_LIMIT(16'h0032)) i_system_clock_source_select (
    .sys_clk(sys_clk), .srst(srst), .clock_source_select(strap), .wake_from_sleep(wake),
    .osc_in_pin(osc), .timer_osc_in(tmr), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .reg_req(req), .reg_rdata(rdata), .irq(irq), .sys_clk_out(clk_out),
    .amp_gain(gain), .osc_out_or_clock_out_pin(pin));
  ext_osc_model i_ext_osc_model (.sys_clk(sys_clk), .run(ext_run), .half(ext_half), .osc(osc));
  ext_osc_model i_ext_osc_model_tmr (.sys_clk(sys_clk), .run(tmr_run), .half(11'h005),
    .osc(tmr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic boot(input logic [2:0] m);
    @(posedge sys_clk);
    srst <= 1'b1;
    strap <= m;
    ext_run <= 1'b1;
    tick(5);
    srst <= 1'b0;
    tick(3);
  endtask : boot
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // counts rising edges of the clock output and of the second pin over n cycles
  task automatic rises(input int w, input int n, output int r, output int rp);
    logic p;
    logic q;
    tick(w);
    #1;
    p = clk_out;
    q = pin.out;
    r = 0;
    rp = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (clk_out && !p) r++;
      if (pin.out && !q) rp++;
      p = clk_out;
      q = pin.out;
    end
  endtask : rises
  task automatic s_ext();
    logic [2:0] codes [4] = '{3'h7, 3'h6, 3'h5, 3'h3};
    logic [7:0] d;
    int r;
    int rp;
    for (int i = 0; i < 4; i++) begin
      boot(codes[i]);
      gpio_oe <= 1'b1;
      gpio_out <= 1'b1;
      rd(clk_sel_pkg::ADDR_STATUS, d);
      chk(d[6:4], codes[i]);
      chk(d[1:0], clk_sel_pkg::SRC_EXT);
      chk({pin.oe_n, pin.out}, 2'h1);
      wr(clk_sel_pkg::ADDR_CTRL, 8'h08);
      rises(10, 60, r, rp);
      chk(r, 10);
      chk(rp, 10);
      chk(gain, clk_sel_pkg::GAIN_OFF);
    end
  endtask : s_ext
  task automatic s_xtal();
    int r;
    int rp;
    ext_half <= 11'h002;
    for (int c = 0; c < 3; c++) begin
      boot(c[2:0]);
      chk(gain, c[1:0] + 2'h1);
      rises(4040, 20, r, rp);
      chk(r, 0);
      rises(80, 40, r, rp);
      chk(r, 10);
    end
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    rises(2, 40, r, rp);
    chk(r, 0);
    ext_half <= 11'h003;
  endtask : s_xtal
  task automatic s_switch();
    int h [3] = '{clk_sel_pkg::HF_HALF, clk_sel_pkg::MF_HALF, clk_sel_pkg::LF_HALF};
    logic [7:0] d;
    int r;
    int rp;
    boot(3'h4);
    rd(clk_sel_pkg::ADDR_STATUS, d);
    chk({d[6:4], d[1:0]}, {3'h4, clk_sel_pkg::SRC_INT});
    boot(3'h7);
    tmr_run <= 1'b1;
    wr(clk_sel_pkg::ADDR_IRQ_CLR, 8'h07);
    wr(clk_sel_pkg::ADDR_IRQ_EN, 8'h04);
    wr(clk_sel_pkg::ADDR_CTRL, 8'h01);
    rises(20, 60, r, rp);
    chk(r, 6);
    rd(clk_sel_pkg::ADDR_IRQ_STAT, d);
    chk({irq, d}, 9'h104);
    for (int f = 0; f < 3; f++) begin
      wr(clk_sel_pkg::ADDR_CTRL, {2'h0, f[1:0], 2'h0, 1'b1, f[0]});
      rises(4 * h[f] + 10, 4 * h[f], r, rp);
      chk(r, 2);
      rd(clk_sel_pkg::ADDR_STATUS, d);
      chk(d[1:0], clk_sel_pkg::SRC_INT);
    end
    wr(clk_sel_pkg::ADDR_CTRL, 8'h00);
    rises(1700, 60, r, rp);
    chk(r, 10);
    tmr_run <= 1'b0;
  endtask : s_switch
  task automatic s_fail();
    logic [7:0] d;
    int r;
    int rp;
    boot(3'h7);
    ext_run <= 1'b0;
    rises(5, 300, r, rp);
    chk(r, 0);
    ext_run <= 1'b1;
    rises(5, 60, r, rp);
    chk(r, 10);
    wr(clk_sel_pkg::ADDR_IRQ_CLR, 8'h07);
    wr(clk_sel_pkg::ADDR_IRQ_EN, 8'h01);
    wr(clk_sel_pkg::ADDR_CTRL, 8'h04);
    rd(clk_sel_pkg::ADDR_IRQ_STAT, d);
    chk({irq, d}, 9'h000);
    ext_run <= 1'b0;
    rises(80, 40, r, rp);
    chk(r, 20);
    rd(clk_sel_pkg::ADDR_STATUS, d);
    chk({irq, d[3], d[1:0]}, 4'hE);
    wr(clk_sel_pkg::ADDR_IRQ_CLR, 8'h01);
    wr(clk_sel_pkg::ADDR_STATUS, 8'h00);
    rd(clk_sel_pkg::ADDR_IRQ_STAT, d);
    chk({irq, d}, 9'h004);
    rd(clk_sel_pkg::ADDR_STATUS, d);
    chk(d[6:4], 3'h7);
    rd(4'hF, d);
    chk(d, 8'h00);
  endtask : s_fail
  task automatic tally_and_finish();
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    s_ext();
    s_xtal();
    s_switch();
    s_fail();
    tally_and_finish();
  end
  initial begin
    tick(60000);
    failures++;
    tally_and_finish();
  end
endmodule : system_clock_source_select_tb_top
`default_nettype wire

// ### hw/clk_sel_pkg.sv
`default_nettype none

package clk_sel_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int HF_OSC_HZ = 16_000_000;
  localparam int MF_OSC_HZ = 500_000;
  localparam int LF_OSC_HZ = 31_000;

  // half period of an internal source in system cycles, rounded down, at least one
  function automatic int half_cycles(input int hz);
    int c;
    c = SYS_CLK_HZ / (2 * hz);
    return (c < 1) ? 1 : c;
  endfunction : half_cycles

  localparam int HF_HALF = half_cycles(HF_OSC_HZ);
  localparam int MF_HALF = half_cycles(MF_OSC_HZ);
  localparam int LF_HALF = half_cycles(LF_OSC_HZ);
  localparam int NUM_INT_SRC = 3;
  localparam int DIV_W = 10;

  localparam int OST_EDGES = 1024;
  localparam int OST_W = 11;
  localparam int FAIL_W = 16;
  localparam int FAIL_LIMIT_DEFAULT = 2000;

  // ------------------------------------------------------------------
  // codes
  // ------------------------------------------------------------------
  localparam logic [2:0] MODE_EXT_HIGH = 3'h7;
  localparam logic [2:0] MODE_EXT_MID = 3'h6;
  localparam logic [2:0] MODE_EXT_LOW = 3'h5;
  localparam logic [2:0] MODE_INTERNAL = 3'h4;
  localparam logic [2:0] MODE_RC = 3'h3;
  localparam logic [2:0] MODE_XTAL_HIGH = 3'h2;
  localparam logic [2:0] MODE_XTAL_MID = 3'h1;
  localparam logic [2:0] MODE_XTAL_LOW = 3'h0;

  localparam logic [1:0] RCS_CONFIG = 2'h0;
  localparam logic [1:0] RCS_TIMER = 2'h1;
  localparam int RCS_INT_BIT = 1;

  localparam logic [1:0] IFREQ_HF = 2'h0;
  localparam logic [1:0] IFREQ_MF = 2'h1;
  localparam logic [1:0] IFREQ_LF = 2'h2;

  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;

  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_LOW = 2'h1;
  localparam logic [1:0] GAIN_MID = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 4'h4;

  localparam int IRQ_W = 3;
  localparam int IRQ_FAIL = 0;
  localparam int IRQ_STARTUP = 1;
  localparam int IRQ_SWITCH = 2;

  typedef struct packed {
    logic [1:0] ifreq;
    logic clkout_en;
    logic fcm_en;
    logic [1:0] rcs;
  } ctrl_t;

  typedef struct packed {
    logic [2:0] mode;
    logic ext_fail;
    logic startup_done;
    logic [1:0] cur_src;
  } status_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;

  typedef enum logic [2:0] {
    SW_RUN = 3'b001,
    SW_ARM = 3'b010,
    SW_HALT = 3'b100
  } sw_state_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] irq_stat;
    logic irq;
    logic [DATA_W-1:0] rdata;
    logic [2:0] mode;
    logic mode_valid;
    logic osc_d;
    logic timer_d;
    logic [OST_W-1:0] ost_cnt;
    logic startup_done;
    logic [FAIL_W-1:0] idle_cnt;
    logic ext_fail;
    logic [1:0] cur_src;
    sw_state_t sw;
    logic clk_out;
    pin_drive_t pin;
    logic [1:0] gain;
  } main_state_t;

  typedef struct packed {
    logic [NUM_INT_SRC-1:0][DIV_W-1:0] cnt;
    logic [NUM_INT_SRC-1:0] lvl;
  } osc_gen_state_t;

endpackage : clk_sel_pkg

`default_nettype wire

// ### hw/internal_osc_gen.sv
`default_nettype none

module internal_osc_gen (
  input wire logic sys_clk,
  input wire logic srst,
  output logic [clk_sel_pkg::NUM_INT_SRC-1:0] osc_lvl
);

  localparam int HALF [clk_sel_pkg::NUM_INT_SRC] = '{
    clk_sel_pkg::HF_HALF, clk_sel_pkg::MF_HALF, clk_sel_pkg::LF_HALF};

  clk_sel_pkg::osc_gen_state_t st;
  clk_sel_pkg::osc_gen_state_t next_st;

  // ------------------------------------------------------------------
  // one square-wave divider per internal source
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    for (int i = 0; i < clk_sel_pkg::NUM_INT_SRC; i++) begin
      if (st.cnt[i] == clk_sel_pkg::DIV_W'(HALF[i] - 1)) begin
        next_st.cnt[i] = '0;
        next_st.lvl[i] = ~st.lvl[i];
      end else begin
        next_st.cnt[i] = st.cnt[i] + clk_sel_pkg::DIV_W'(1);
      end
    end
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign osc_lvl = st.lvl;

endmodule : internal_osc_gen

`default_nettype wire

// ### hw/system_clock_source_select.sv
// Functional notes
// - Eight modes picked by captured source select
// - Codes 111/110/101 are external clock powers
// - External clock modes skip the startup count
// - Stopped source freezes state, resumes unchanged
// - External clock in; out pin GPIO or clock
// - Runtime select picks timer osc or configured source
// - Lost external clock falls back to internal
// - Internal sources: 16 MHz, 500 kHz, 31 kHz; HF comes out at 25 MHz, its half period floored to one 50 MHz cycle
// - Crystal modes set low/mid/high amplifier gain
// - Codes 100/011/010/001/000 internal, RC, crystals
// - Crystal modes wait 1024 edges after reset/wake
// - Runtime select 1x picks internal oscillator
`default_nettype none

module system_clock_source_select #(
  parameter logic [clk_sel_pkg::FAIL_W-1:0] FAIL_LIMIT =
    clk_sel_pkg::FAIL_W'(clk_sel_pkg::FAIL_LIMIT_DEFAULT)
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [2:0] clock_source_select,
  input wire logic wake_from_sleep,
  input wire logic osc_in_pin,
  input wire logic timer_osc_in,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire clk_sel_pkg::reg_req_t reg_req,
  output logic [clk_sel_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  output logic sys_clk_out,
  output logic [1:0] amp_gain,
  output clk_sel_pkg::pin_drive_t osc_out_or_clock_out_pin
);

  clk_sel_pkg::main_state_t st;
  clk_sel_pkg::main_state_t next_st;
  logic [clk_sel_pkg::NUM_INT_SRC-1:0] int_lvl;

  internal_osc_gen u_int_osc (
    .sys_clk(sys_clk),
    .srst(srst),
    .osc_lvl(int_lvl)
  );

  // ------------------------------------------------------------------
  // level of a source as seen on the system clock
  // ------------------------------------------------------------------
  function automatic logic src_level(input logic [1:0] src, input logic osc,
                                     input logic tmr, input logic [1:0] ifreq,
                                     input logic [clk_sel_pkg::NUM_INT_SRC-1:0] il);
    logic l;
    l = 1'b0;
    if (src == clk_sel_pkg::SRC_EXT) begin
      l = osc;
    end else if (src == clk_sel_pkg::SRC_TIMER) begin
      l = tmr;
    end else if (ifreq == clk_sel_pkg::IFREQ_MF) begin
      l = il[1];
    end else if (ifreq == clk_sel_pkg::IFREQ_LF) begin
      l = il[2];
    end else begin
      l = il[0];
    end
    return l;
  endfunction : src_level

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic osc_rise;
    logic crystal;
    logic internal_mode;
    logic ready;
    logic [1:0] want;
    logic cur_lvl;
    clk_sel_pkg::status_t stat;
    osc_rise = 1'b0;
    crystal = 1'b0;
    internal_mode = 1'b0;
    ready = 1'b0;
    want = clk_sel_pkg::SRC_EXT;
    cur_lvl = 1'b0;
    stat = '0;
    next_st = st;

    // the edge detector is cleared by reset, so ignore it until the mode is caught
    osc_rise = osc_in_pin & ~st.osc_d & st.mode_valid;
    next_st.osc_d = osc_in_pin;
    next_st.timer_d = timer_osc_in;

    // source select is caught once, the first cycle after reset
    if (!st.mode_valid) begin
      next_st.mode = clock_source_select;
      next_st.mode_valid = 1'b1;
    end
    crystal = (st.mode == clk_sel_pkg::MODE_XTAL_LOW) ||
              (st.mode == clk_sel_pkg::MODE_XTAL_MID) ||
              (st.mode == clk_sel_pkg::MODE_XTAL_HIGH);
    internal_mode = (st.mode == clk_sel_pkg::MODE_INTERNAL);

    // ----------------------------------------------------------------
    // register writes; clears are applied before events so sets win
    // ----------------------------------------------------------------
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        clk_sel_pkg::ADDR_CTRL: begin
          next_st.ctrl = clk_sel_pkg::ctrl_t'(reg_req.wdata[$bits(clk_sel_pkg::ctrl_t)-1:0]);
        end
        clk_sel_pkg::ADDR_IRQ_CLR: begin
          next_st.irq_stat = st.irq_stat & ~reg_req.wdata[clk_sel_pkg::IRQ_W-1:0];
        end
        clk_sel_pkg::ADDR_IRQ_EN: begin
          next_st.irq_en = reg_req.wdata[clk_sel_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // crystal startup counter
    // ----------------------------------------------------------------
    if (wake_from_sleep) begin
      next_st.ost_cnt = '0;
      next_st.startup_done = ~crystal;
      next_st.idle_cnt = '0;
      next_st.ext_fail = 1'b0;
    end else if (!crystal) begin
      next_st.startup_done = st.mode_valid;
    end else if (!st.startup_done && osc_rise) begin
      if (st.ost_cnt == clk_sel_pkg::OST_W'(clk_sel_pkg::OST_EDGES - 1)) begin
        next_st.startup_done = 1'b1;
        next_st.irq_stat[clk_sel_pkg::IRQ_STARTUP] = 1'b1;
      end else begin
        next_st.ost_cnt = st.ost_cnt + clk_sel_pkg::OST_W'(1);
      end
    end

    // ----------------------------------------------------------------
    // fail-safe monitor: too long with no edge on the oscillator input
    // ----------------------------------------------------------------
    if (!wake_from_sleep && st.mode_valid && !internal_mode && st.ctrl.fcm_en &&
        !st.ext_fail) begin
      if (osc_rise) begin
        next_st.idle_cnt = '0;
      end else if (st.idle_cnt == FAIL_LIMIT - clk_sel_pkg::FAIL_W'(1)) begin
        next_st.ext_fail = 1'b1;
        next_st.irq_stat[clk_sel_pkg::IRQ_FAIL] = 1'b1;
      end else begin
        next_st.idle_cnt = st.idle_cnt + clk_sel_pkg::FAIL_W'(1);
      end
    end

    // ----------------------------------------------------------------
    // wanted source
    // ----------------------------------------------------------------
    ready = st.mode_valid;
    if (internal_mode || st.ctrl.rcs[clk_sel_pkg::RCS_INT_BIT]) begin
      want = clk_sel_pkg::SRC_INT;
    end else if (st.ctrl.rcs == clk_sel_pkg::RCS_TIMER) begin
      want = clk_sel_pkg::SRC_TIMER;
    end else if (st.ext_fail) begin
      want = clk_sel_pkg::SRC_INT;
    end else if (!st.startup_done) begin
      // with the monitor on, run internal while the crystal settles
      want = clk_sel_pkg::SRC_INT;
      ready = st.mode_valid && st.ctrl.fcm_en;
    end else begin
      want = clk_sel_pkg::SRC_EXT;
    end

    // ----------------------------------------------------------------
    // glitch-free switch: leave old source only while low, join new
    // source only after seeing it low, so every phase is whole
    // ----------------------------------------------------------------
    cur_lvl = src_level(st.cur_src, st.osc_d, st.timer_d, st.ctrl.ifreq, int_lvl);
    unique case (st.sw)
      clk_sel_pkg::SW_HALT: begin
        next_st.clk_out = 1'b0;
        if (ready) begin
          next_st.cur_src = want;
          next_st.sw = clk_sel_pkg::SW_ARM;
        end
      end
      clk_sel_pkg::SW_RUN: begin
        // a stopped source simply holds the output and all state
        next_st.clk_out = cur_lvl;
        if (!ready && !cur_lvl) begin
          next_st.sw = clk_sel_pkg::SW_HALT;
        end else if (want != st.cur_src && !cur_lvl) begin
          next_st.cur_src = want;
          next_st.sw = clk_sel_pkg::SW_ARM;
        end
      end
      clk_sel_pkg::SW_ARM: begin
        next_st.clk_out = 1'b0;
        if (!cur_lvl) begin
          next_st.sw = clk_sel_pkg::SW_RUN;
          next_st.irq_stat[clk_sel_pkg::IRQ_SWITCH] = 1'b1;
        end
      end
      default: begin
        next_st.sw = clk_sel_pkg::SW_HALT;
        next_st.clk_out = 1'b0;
      end
    endcase

    // ----------------------------------------------------------------
    // amplifier gain and second oscillator pin
    // ----------------------------------------------------------------
    unique case (st.mode)
      clk_sel_pkg::MODE_XTAL_LOW: next_st.gain = clk_sel_pkg::GAIN_LOW;
      clk_sel_pkg::MODE_XTAL_MID: next_st.gain = clk_sel_pkg::GAIN_MID;
      clk_sel_pkg::MODE_XTAL_HIGH: next_st.gain = clk_sel_pkg::GAIN_HIGH;
      default: next_st.gain = clk_sel_pkg::GAIN_OFF;
    endcase
    if (crystal) begin
      next_st.pin.out = ~osc_in_pin;
      next_st.pin.oe_n = 1'b0;
    end else if (st.ctrl.clkout_en) begin
      next_st.pin.out = next_st.clk_out;
      next_st.pin.oe_n = 1'b0;
    end else begin
      next_st.pin.out = gpio_out;
      next_st.pin.oe_n = ~gpio_oe;
    end

    // ----------------------------------------------------------------
    // read data, valid only the cycle after the read strobe
    // ----------------------------------------------------------------
    stat.mode = st.mode;
    stat.ext_fail = st.ext_fail;
    stat.startup_done = st.startup_done;
    stat.cur_src = st.cur_src;
    next_st.rdata = '0;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        clk_sel_pkg::ADDR_CTRL: next_st.rdata = clk_sel_pkg::DATA_W'(st.ctrl);
        clk_sel_pkg::ADDR_STATUS: next_st.rdata = clk_sel_pkg::DATA_W'(stat);
        clk_sel_pkg::ADDR_IRQ_STAT: next_st.rdata = clk_sel_pkg::DATA_W'(st.irq_stat);
        clk_sel_pkg::ADDR_IRQ_EN: next_st.rdata = clk_sel_pkg::DATA_W'(st.irq_en);
        default: next_st.rdata = '0;
      endcase
    end

    next_st.irq = |(next_st.irq_stat & next_st.irq_en);

    if (srst) begin
      next_st = '0;
      next_st.sw = clk_sel_pkg::SW_HALT;
      next_st.pin.oe_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign irq = st.irq;
  assign sys_clk_out = st.clk_out;
  assign amp_gain = st.gain;
  assign osc_out_or_clock_out_pin = st.pin;

endmodule : system_clock_source_select

`default_nettype wire
